/* File: core/lil_top.sv */
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Contract
// - Latch setting holds LED after pickup; defaults per group
// - Ack clears held LED only after inputs gone
// - Ack selection acts only while latching enabled
// - OR true shows configured active colour, default red
// - OR false shows configured inactive colour unless held, default off
// - Each input has own inversion, default off
module lil_top #(
    parameter int GROUP_LEDS     = lil_pkg::GROUP_LEDS,
    parameter int NUM_SIG        = lil_pkg::NUM_SIG,
    parameter int FLASH_HALF_CYC = lil_pkg::FLASH_HALF_CYC
) (
    // Clock, reset, enable
    input  wire logic                          clk_sys_i,
    input  wire logic                          rstn_i,
    input  wire logic                          en_i,
    // Register port
    input  wire logic [lil_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [lil_pkg::DATA_W-1:0]    wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic [lil_pkg::DATA_W-1:0]         rdata_o,
    // Protection signals
    input  wire logic [NUM_SIG-1:0]            sig_i,
    // LED drive
    output lil_pkg::lil_lamp_t [2*GROUP_LEDS-1:0] lamp_o
);

    localparam int NUM_LED = 2 * GROUP_LEDS;
    localparam int FLASH_W = $clog2(FLASH_HALF_CYC + 1);
    localparam int IDX_W   = lil_pkg::ADDR_W - lil_pkg::LED_LSB;

    lil_pkg::lil_cfg_t            cfg_reg   [NUM_LED];
    lil_pkg::lil_cfg_t            cfg_next  [NUM_LED];
    logic [lil_pkg::DATA_W-1:0]   rdata_reg;
    logic [lil_pkg::DATA_W-1:0]   rdata_next;
    logic [FLASH_W-1:0]           flash_cnt_reg;
    logic [FLASH_W-1:0]           flash_cnt_next;
    logic                         flash_reg;
    logic                         flash_next;
    logic [NUM_LED-1:0]           or_w;
    logic [NUM_LED-1:0]           held_w;
    logic [NUM_LED-1:0]           act_w;
    logic [IDX_W-1:0]             led_idx;
    logic [1:0]                   word_idx;
    logic                         mapped;

    assign led_idx  = addr_i[lil_pkg::ADDR_W-1:lil_pkg::LED_LSB];
    assign word_idx = addr_i[lil_pkg::LED_LSB-1:lil_pkg::WORD_LSB];
    assign mapped   = (addr_i[lil_pkg::WORD_LSB-1:0] == 2'h0) && (int'(led_idx) < NUM_LED);

    // Flash phase shared by all LEDs so flashing ones blink in step
    always_comb begin
        flash_cnt_next = flash_cnt_reg;
        flash_next     = flash_reg;
        if (int'(flash_cnt_reg) >= FLASH_HALF_CYC - 1) begin
            flash_cnt_next = '0;
            flash_next     = ~flash_reg;
        end else begin
            flash_cnt_next = flash_cnt_reg + FLASH_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flash_cnt_reg <= '0;
            flash_reg     <= 1'b0;
        end else if (en_i) begin
            flash_cnt_reg <= flash_cnt_next;
            flash_reg     <= flash_next;
        end
    end

    // Settings: writes to other fields leave the stored values alone
    always_comb begin
        for (int i = 0; i < NUM_LED; i++) begin
            cfg_next[i] = cfg_reg[i];
            if (wr_i && mapped && int'(led_idx) == i) begin
                case (word_idx)
                    lil_pkg::REG_CFG: begin
                        cfg_next[i].latch     = wdata_i[lil_pkg::CFG_LATCH_BIT];
                        cfg_next[i].act_col   = lil_pkg::lil_col_t'(
                            wdata_i[lil_pkg::CFG_ACT_LSB +: lil_pkg::COL_W]);
                        cfg_next[i].inact_col = lil_pkg::lil_col_t'(
                            wdata_i[lil_pkg::CFG_INACT_LSB +: lil_pkg::COL_W]);
                        cfg_next[i].invert    =
                            wdata_i[lil_pkg::CFG_INV_LSB +: lil_pkg::NUM_SRC];
                    end
                    lil_pkg::REG_SEL: begin
                        for (int k = 0; k < lil_pkg::NUM_SRC; k++) begin
                            cfg_next[i].sel[k] = wdata_i[k*lil_pkg::SEL_W +: lil_pkg::SEL_W];
                        end
                    end
                    lil_pkg::REG_ACK: begin
                        cfg_next[i].ack_sel = wdata_i[lil_pkg::SEL_W-1:0];
                    end
                    default: begin
                        cfg_next[i] = cfg_reg[i];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_LED; i++) begin
                cfg_reg[i] <= (i < GROUP_LEDS) ? lil_pkg::RST_CFG_A : lil_pkg::RST_CFG_B;
            end
        end else if (en_i) begin
            for (int i = 0; i < NUM_LED; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_comb begin
        rdata_next = '0;
        if (rd_i && mapped) begin
            for (int i = 0; i < NUM_LED; i++) begin
                if (int'(led_idx) == i) begin
                    case (word_idx)
                        lil_pkg::REG_CFG: begin
                            rdata_next[lil_pkg::CFG_LATCH_BIT] = cfg_reg[i].latch;
                            rdata_next[lil_pkg::CFG_ACT_LSB +: lil_pkg::COL_W] =
                                cfg_reg[i].act_col;
                            rdata_next[lil_pkg::CFG_INACT_LSB +: lil_pkg::COL_W] =
                                cfg_reg[i].inact_col;
                            rdata_next[lil_pkg::CFG_INV_LSB +: lil_pkg::NUM_SRC] =
                                cfg_reg[i].invert;
                        end
                        lil_pkg::REG_SEL: begin
                            for (int k = 0; k < lil_pkg::NUM_SRC; k++) begin
                                rdata_next[k*lil_pkg::SEL_W +: lil_pkg::SEL_W] =
                                    cfg_reg[i].sel[k];
                            end
                        end
                        lil_pkg::REG_ACK: begin
                            // Hidden while not latching
                            if (cfg_reg[i].latch) begin
                                rdata_next[lil_pkg::SEL_W-1:0] = cfg_reg[i].ack_sel;
                            end
                        end
                        default: begin
                            rdata_next[lil_pkg::STAT_OR_BIT]    = or_w[i];
                            rdata_next[lil_pkg::STAT_HELD_BIT]  = held_w[i];
                            rdata_next[lil_pkg::STAT_ACT_BIT]   = act_w[i];
                            rdata_next[lil_pkg::STAT_GREEN_BIT] = lamp_o[i].green;
                            rdata_next[lil_pkg::STAT_RED_BIT]   = lamp_o[i].red;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= '0;
        end else if (en_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    for (genvar g = 0; g < NUM_LED; g++) begin : g_led
        lil_led #(
            .NUM_SIG (NUM_SIG)
        ) u_led (
            .clk_sys_i (clk_sys_i),
            .rstn_i    (rstn_i),
            .en_i      (en_i),
            .sig_i     (sig_i),
            .cfg_i     (cfg_reg[g]),
            .flash_i   (flash_reg),
            .lamp_o    (lamp_o[g]),
            .or_o      (or_w[g]),
            .held_o    (held_w[g]),
            .act_o     (act_w[g])
        );
    end

    // LED 1 is the one whose first input gets inverted in practice
    AST_INVERT_FIRST: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && cfg_reg[1].invert[0] && cfg_reg[1].sel[0] != '0
         && int'(cfg_reg[1].sel[0]) <= NUM_SIG && !sig_i[int'(cfg_reg[1].sel[0]) - 1])
        |=> or_w[1])
        else $error("inverted low input did not raise OR");

    AST_ACK_HIDDEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && rd_i && mapped && word_idx == lil_pkg::REG_ACK
         && !cfg_reg[led_idx].latch) |=> (rdata_o == '0))
        else $error("ack selection visible while latching off");

    AST_GROUP_B_UNLATCHED: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> (!cfg_reg[GROUP_LEDS].latch && cfg_reg[0].latch))
        else $error("latch defaults wrong after reset");

    // Colour and inversion defaults are the same in both groups
    AST_COLOUR_DEFAULTS: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> (cfg_reg[0].act_col == lil_pkg::COL_RED
                           && cfg_reg[GROUP_LEDS].act_col == lil_pkg::COL_RED))
        else $error("active colour default wrong after reset");

    AST_INACT_DEFAULTS: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> (cfg_reg[0].inact_col == lil_pkg::COL_OFF
                           && cfg_reg[GROUP_LEDS].inact_col == lil_pkg::COL_OFF))
        else $error("inactive colour default wrong after reset");

    AST_INVERT_DEFAULTS: assert property (@(posedge clk_sys_i)
        $rose(rstn_i) |-> (cfg_reg[0].invert == '0 && cfg_reg[GROUP_LEDS].invert == '0))
        else $error("inversion not off after reset");

    AST_ACK_SEL_SHOWN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && rd_i && mapped && word_idx == lil_pkg::REG_ACK && cfg_reg[led_idx].latch)
        |=> (rdata_o[lil_pkg::SEL_W-1:0] == $past(cfg_reg[led_idx].ack_sel)))
        else $error("ack selection not shown while latching");

    // Phase may only turn at the end of a half period, never while frozen
    AST_FLASH_STEADY: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (!en_i || int'(flash_cnt_reg) < FLASH_HALF_CYC - 1) |=> $stable(flash_reg))
        else $error("flash phase turned early");

endmodule

/* File: core/lil_pkg.sv */
package lil_pkg;

    // Sizes
    localparam int GROUP_LEDS  = 5;
    localparam int NUM_SIG     = 32;
    localparam int NUM_SRC     = 5;
    localparam int SEL_W       = 6;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;

    // Address layout: LED index above, word index below
    localparam int WORD_LSB    = 2;
    localparam int LED_LSB     = 4;
    localparam logic [1:0] REG_CFG  = 2'h0;
    localparam logic [1:0] REG_SEL  = 2'h1;
    localparam logic [1:0] REG_ACK  = 2'h2;
    localparam logic [1:0] REG_STAT = 2'h3;

    // Field positions
    localparam int CFG_LATCH_BIT = 0;
    localparam int CFG_ACT_LSB   = 1;
    localparam int CFG_INACT_LSB = 4;
    localparam int CFG_INV_LSB   = 7;
    localparam int COL_W         = 3;
    localparam int STAT_OR_BIT    = 0;
    localparam int STAT_HELD_BIT  = 1;
    localparam int STAT_ACT_BIT   = 2;
    localparam int STAT_GREEN_BIT = 3;
    localparam int STAT_RED_BIT   = 4;

    // Timing
    localparam int CLK_FREQ_HZ    = 20_000_000;
    localparam int FLASH_HALF_MS  = 500;
    localparam int FLASH_HALF_CYC = (CLK_FREQ_HZ / 1000) * FLASH_HALF_MS;

    typedef enum logic [2:0] {
        COL_OFF         = 3'h0,
        COL_GREEN       = 3'h1,
        COL_RED         = 3'h2,
        COL_RED_FLASH   = 3'h3,
        COL_GREEN_FLASH = 3'h4
    } lil_col_t;

    typedef enum logic {
        HOLD_IDLE = 1'b0,
        HOLD_SET  = 1'b1
    } lil_hold_t;

    typedef struct packed {
        logic                              latch;
        lil_col_t                          act_col;
        lil_col_t                          inact_col;
        logic [NUM_SRC-1:0]                invert;
        logic [NUM_SRC-1:0][SEL_W-1:0]     sel;
        logic [SEL_W-1:0]                  ack_sel;
    } lil_cfg_t;

    typedef struct packed {
        logic green;
        logic red;
    } lil_lamp_t;

    // Reset values
    localparam lil_cfg_t RST_CFG_A = '{latch: 1'b1, act_col: COL_RED, inact_col: COL_OFF,
                                       invert: '0, sel: '0, ack_sel: '0};
    localparam lil_cfg_t RST_CFG_B = '{latch: 1'b0, act_col: COL_RED, inact_col: COL_OFF,
                                       invert: '0, sel: '0, ack_sel: '0};

endpackage

/* File: core/lil_led.sv */
`timescale 1ns/1ps
module lil_led #(
    parameter int NUM_SIG = lil_pkg::NUM_SIG
) (
    // Clock, reset, enable
    input  wire logic                clk_sys_i,
    input  wire logic                rstn_i,
    input  wire logic                en_i,
    // Signals and settings
    input  wire logic [NUM_SIG-1:0]  sig_i,
    input  wire lil_pkg::lil_cfg_t   cfg_i,
    input  wire logic                flash_i,
    // Indication
    output lil_pkg::lil_lamp_t       lamp_o,
    output logic                     or_o,
    output logic                     held_o,
    output logic                     act_o
);

    lil_pkg::lil_hold_t        hold_reg;
    lil_pkg::lil_hold_t        hold_next;
    lil_pkg::lil_lamp_t        lamp_reg;
    lil_pkg::lil_lamp_t        lamp_next;
    logic                      or_reg;
    logic                      act_reg;
    logic [lil_pkg::NUM_SRC-1:0] src_vec;
    logic                      or_now;
    logic                      ack_bit;
    logic                      ack_now;
    logic                      act_next;
    lil_pkg::lil_col_t         col;

    always_comb begin
        src_vec = '0;
        ack_bit = 1'b0;
        // Selector zero means unassigned; it never contributes, inverted or not
        for (int k = 0; k < lil_pkg::NUM_SRC; k++) begin
            if (int'(cfg_i.sel[k]) != 0 && int'(cfg_i.sel[k]) <= NUM_SIG) begin
                src_vec[k] = sig_i[int'(cfg_i.sel[k]) - 1] ^ cfg_i.invert[k];
            end
        end
        if (int'(cfg_i.ack_sel) != 0 && int'(cfg_i.ack_sel) <= NUM_SIG) begin
            ack_bit = sig_i[int'(cfg_i.ack_sel) - 1];
        end
        or_now  = |src_vec;
        ack_now = cfg_i.latch & ack_bit;
        case (hold_reg)
            lil_pkg::HOLD_IDLE: begin
                hold_next = (cfg_i.latch && or_now) ? lil_pkg::HOLD_SET
                                                    : lil_pkg::HOLD_IDLE;
            end
            lil_pkg::HOLD_SET: begin
                // Ack only counts once every initiating input has gone
                if (!cfg_i.latch || (ack_now && !or_now)) begin
                    hold_next = lil_pkg::HOLD_IDLE;
                end else begin
                    hold_next = lil_pkg::HOLD_SET;
                end
            end
            default: hold_next = lil_pkg::HOLD_IDLE;
        endcase
        act_next = or_now | (hold_next == lil_pkg::HOLD_SET);
        col = act_next ? cfg_i.act_col : cfg_i.inact_col;
        case (col)
            lil_pkg::COL_GREEN:       lamp_next = '{green: 1'b1, red: 1'b0};
            lil_pkg::COL_RED:         lamp_next = '{green: 1'b0, red: 1'b1};
            lil_pkg::COL_RED_FLASH:   lamp_next = '{green: 1'b0, red: flash_i};
            lil_pkg::COL_GREEN_FLASH: lamp_next = '{green: flash_i, red: 1'b0};
            default:                  lamp_next = '{green: 1'b0, red: 1'b0};
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_reg <= lil_pkg::HOLD_IDLE;
            lamp_reg <= '0;
            or_reg   <= 1'b0;
            act_reg  <= 1'b0;
        end else if (en_i) begin
            hold_reg <= hold_next;
            lamp_reg <= lamp_next;
            or_reg   <= or_now;
            act_reg  <= act_next;
        end
    end

    assign lamp_o = lamp_reg;
    assign or_o   = or_reg;
    assign held_o = (hold_reg == lil_pkg::HOLD_SET);
    assign act_o  = act_reg;

    AST_PICKUP_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && cfg_i.latch && or_now) |=> (held_o && act_o))
        else $error("latched LED did not hold after pickup");

    AST_ACK_IGNORED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && held_o && cfg_i.latch && ack_bit && or_now) |=> held_o)
        else $error("ack cleared LED while an input was still present");

    AST_ACK_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && held_o && cfg_i.latch && ack_bit && !or_now) |=> (!held_o && !act_o))
        else $error("valid ack did not clear held LED");

    AST_FOLLOW_UNLATCHED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && !cfg_i.latch) |=> (!held_o && act_o == $past(or_now)))
        else $error("unlatched LED did not follow OR result");

    AST_ACTIVE_RED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && or_now && cfg_i.act_col == lil_pkg::COL_RED) |=> (lamp_o.red && !lamp_o.green))
        else $error("active LED not shown red");

    AST_INACTIVE_GREEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (en_i && !act_next && cfg_i.inact_col == lil_pkg::COL_GREEN)
        |=> (lamp_o.green && !lamp_o.red && !act_o))
        else $error("inactive LED not shown green");

endmodule

/* File: verif/lil_sig_src.sv */
`timescale 1ns/1ps
// Protection signal source; applies a change after a chosen delay, a new request replacing any pending one
module lil_sig_src #(
    parameter int NUM_SIG = lil_pkg::NUM_SIG
) (
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                rstn_i,
    // Change request
    input  wire logic                req_i,
    input  wire logic [4:0]          idx_i,
    input  wire logic                val_i,
    input  wire logic [3:0]          dly_i,
    // Signals towards the block
    output logic [NUM_SIG-1:0]       sig_o
);
    logic [3:0] cnt_reg;
    logic [4:0] idx_reg;
    logic       val_reg;
    logic       busy_reg;

    // Delay lets a slow source be imitated beside a prompt one
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sig_o    <= '0;
            cnt_reg  <= 4'h0;
            idx_reg  <= 5'h0;
            val_reg  <= 1'b0;
            busy_reg <= 1'b0;
        end else if (req_i) begin
            cnt_reg  <= dly_i;
            idx_reg  <= idx_i;
            val_reg  <= val_i;
            busy_reg <= 1'b1;
        end else if (busy_reg && cnt_reg == 4'h0) begin
            sig_o[idx_reg] <= val_reg;
            busy_reg       <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule

/* File: verif/tb_lil_top.sv */
`timescale 1ns/1ps
module tb_lil_top;
    logic                          clk_sys_i;
    logic                          rstn_i;
    logic                          en_i;
    logic [7:0]                    addr_i;
    logic [31:0]                   wdata_i;
    logic                          wr_i;
    logic                          rd_i;
    logic [31:0]                   rdata_o;
    logic [31:0]                   sig;
    lil_pkg::lil_lamp_t [9:0]      lamp;
    logic                          req;
    logic [4:0]                    idx;
    logic                          val;
    logic [3:0]                    dly;
    logic [31:0]                   d;
    logic [19:0]                   snap;
    int                            n_fail;
    int                            n_checks;
    int                            cyc;

    lil_top #(.FLASH_HALF_CYC(4)) uut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .en_i(en_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sig_i(sig), .lamp_o(lamp));

    lil_sig_src src (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .idx_i(idx),
        .val_i(val), .dly_i(dly), .sig_o(sig));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic test_done();
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, d);
        chk(nm, exp, d);
    endtask

    // Request reaches the lamps one edge after the source applies it
    task automatic set_sig(input logic [4:0] i, input logic v, input logic [3:0] w);
        @(posedge clk_sys_i);
        req <= 1'b1;
        idx <= i;
        val <= v;
        dly <= w;
        @(posedge clk_sys_i);
        req <= 1'b0;
        repeat (int'(w) + 4) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk_lamp(input int n, input logic [1:0] exp);
        chk($sformatf("lamp%0d", n), {30'h0, exp}, {30'h0, lamp[n]});
    endtask

    // Steady colour must hold every cycle; flash must show lit and dark only
    task automatic chk_show(input int n, input logic [1:0] lit, input logic fl);
        int n_on;
        int n_off;
        n_on  = 0;
        n_off = 0;
        repeat (12) begin
            @(posedge clk_sys_i);
            #1;
            if (lamp[n] === lit) n_on++;
            if (lamp[n] === 2'h0) n_off++;
        end
        chk($sformatf("show%0d", n), {30'h0, !fl, fl},
            {30'h0, n_on == 12, n_on > 0 && n_off > 0 && n_on + n_off == 12});
    endtask

    logic [1:0] lit_tab [5] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h2};

    initial begin
        rstn_i = 1'b0; en_i = 1'b1; addr_i = 8'h00; wdata_i = 32'h0;
        wr_i = 1'b0; rd_i = 1'b0; req = 1'b0; idx = 5'h0; val = 1'b0; dly = 4'h0;
        n_fail = 0; n_checks = 0; cyc = 0;
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rd_chk("cfg_led0", 8'h00, 32'h5);
        rd_chk("cfg_led5", 8'h50, 32'h4);
        chk("lamps_idle", 32'h0, {12'h0, lamp});
        wr_reg(8'ha0, 32'h1);
        rd_chk("unmapped_led", 8'ha0, 32'h0);
        rd_chk("unaligned", 8'h01, 32'h0);
        // Latched LED 0: input on sig0, acknowledge on sig1
        wr_reg(8'h04, 32'h1);
        wr_reg(8'h08, 32'h2);
        rd_chk("ack_sel0", 8'h08, 32'h2);
        set_sig(5'd0, 1'b1, 4'h0);
        chk_lamp(0, 2'h1);
        set_sig(5'd1, 1'b1, 4'h0);
        set_sig(5'd1, 1'b0, 4'h0);
        set_sig(5'd0, 1'b0, 4'h5);
        chk_lamp(0, 2'h1);
        rd_chk("stat_led0", 8'h0c, 32'h16);
        set_sig(5'd1, 1'b1, 4'h0);
        chk_lamp(0, 2'h0);
        set_sig(5'd1, 1'b0, 4'h0);
        // Unlatched LED 5 follows its input; ack selector hidden
        wr_reg(8'h54, 32'h1);
        wr_reg(8'h58, 32'h3);
        rd_chk("ack_sel5", 8'h58, 32'h0);
        set_sig(5'd0, 1'b1, 4'h0);
        chk_lamp(5, 2'h1);
        set_sig(5'd0, 1'b0, 4'h0);
        chk_lamp(5, 2'h0);
        // LED 1 inverted input on sig2, green active, red inactive
        wr_reg(8'h10, 32'ha2);
        wr_reg(8'h14, 32'h3);
        repeat (3) @(posedge clk_sys_i);
        #1 chk_lamp(1, 2'h2);
        set_sig(5'd2, 1'b1, 4'h0);
        chk_lamp(1, 2'h1);
        // LED 6: every colour as active, then as inactive
        wr_reg(8'h64, 32'h4);
        set_sig(5'd3, 1'b1, 4'h0);
        for (int i = 0; i < 10; i++) begin
            if (i == 5) set_sig(5'd3, 1'b0, 4'h0);
            wr_reg(8'h60, (i < 5) ? 32'(i) << 1 : 32'(i - 5) << 4);
            repeat (2) @(posedge clk_sys_i);
            chk_show(6, lit_tab[i % 5], (i % 5) > 2);
        end
        // Enable low freezes the lamps
        @(posedge clk_sys_i);
        en_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 snap = lamp;
        set_sig(5'd3, 1'b1, 4'h0);
        chk("frozen", {12'h0, snap}, {12'h0, lamp});
        @(posedge clk_sys_i);
        en_i <= 1'b1;
        // Spare colour codes show nothing
        wr_reg(8'h60, 32'h4e);
        repeat (2) @(posedge clk_sys_i);
        chk_show(6, 2'h0, 1'b0);
        test_done();
    end
endmodule
